/* File: design/pioc_map.vh */
// constants for the programmable pad cell: register offsets, field positions, reset values
// assumes inclusion by the cell only; the storage element does not include it
`ifndef PIOC_MAP_VH
`define PIOC_MAP_VH

`define PIOC_ADDR_W 4
`define PIOC_DATA_W 32
`define PIOC_OFS_CONFIG 4'h0
`define PIOC_OFS_STATUS 4'h4

// configuration register fields
`define PIOC_CFG_CLK_FALL 0
`define PIOC_CFG_CAP_LATCH 1
`define PIOC_CFG_DRV_LATCH 2
`define PIOC_CFG_OE_LATCH 3
`define PIOC_CFG_CAP_SRVAL 4
`define PIOC_CFG_DRV_SRVAL 5
`define PIOC_CFG_OE_SRVAL 6
`define PIOC_CFG_CAP_DELAY 7
`define PIOC_CFG_B_SEL_LO 8
`define PIOC_CFG_B_SEL_HI 9
`define PIOC_CFG_A_REG 10
`define PIOC_CFG_DRV_BYP 11
`define PIOC_CFG_OE_BYP 12
`define PIOC_CFG_W 13
`define PIOC_CFG_RESET 13'h0000

// result b selector codes
`define PIOC_BSEL_FEED 2'h0
`define PIOC_BSEL_BYPASS 2'h1
`define PIOC_BSEL_Q 2'h2
`define PIOC_BSEL_SERIAL 2'h3

// status register fields
`define PIOC_ST_CAP_Q 0
`define PIOC_ST_DRV_Q 1
`define PIOC_ST_OE_Q 2
`define PIOC_ST_PAD_RX 3
`define PIOC_ST_SER_B 4
`define PIOC_ST_W 5

// storage element indices
`define PIOC_N_STOR 3
`define PIOC_IDX_CAP 0
`define PIOC_IDX_DRV 1
`define PIOC_IDX_OE 2

// capture delay depth in core clock cycles
`define PIOC_CAP_DELAY_STAGES 2

`endif

/* File: design/pioc_stor.v */
// one storage element of the pad cell: latch or edge flip-flop with set/reset
// assumes edge and gate qualifiers are built by the cell from its sampled cell clock
module pioc_stor (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire edge_i,
    input wire gate_i,
    input wire latch_mode_i,
    input wire ce_i,
    input wire sr_i,
    input wire sr_val_i,
    input wire d_i,
    output reg q_o
);

    wire load;

    // latch follows d while gated, flip-flop takes d on the active edge only
    assign load = ce_i & (latch_mode_i ? gate_i : edge_i);

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_o <= 1'b0;
        end else if (sr_i) begin
            // set/reset wins over clock enable
            q_o <= sr_val_i;
        end else if (load) begin
            q_o <= d_i;
        end
    end

endmodule // pioc_stor

/* File: design/pioc_cell.v */
// programmable pad cell: capture, drive and drive-enable storage between fabric and pad buffer
// assumes fabric and serial block signals share core_clk_i; the pad receive level is asynchronous
//
// Operation
// RQ1: the cell takes eleven inputs, nine from the routing fabric plus pad receive data and global set/reset, and gives five outputs.
// RQ2: results a and b and the drive enable go to the fabric, and pad data and pad enable go straight to the pad buffer.
// RQ3: a cell paired with a serial block has two extra inputs from it and two extra outputs to it.
// RQ4: one serial input passes straight to the fabric, the other joins feed-through, bypass and register output on the result b selector.
// RQ5: the two outputs to the serial block equal the pad data and pad enable.
// RQ6: the cell holds a capture register, an output data register and an output enable register.
// RQ7: a selectable delay can slow incoming data before the capture register.
// RQ8: each register's set/reset is the OR of the global set/reset and its local set/reset.
// RQ9: one set/reset and clock enable pair serves capture only, the other serves output data and output enable together.
// RQ10: one cell clock drives all three registers and its active edge is selectable.
// RQ11: each storage element is selectable as a level latch or an edge flip-flop.
// RQ12: the cell makes its own output enable and also presents it to the enclosing pad cluster.
// RQ13: a per-register bit chooses whether set/reset forces one or zero, and set/reset ignores clock enable.
`include "pioc_map.vh"

module pioc_cell #(
    parameter CAP_DELAY_STAGES = `PIOC_CAP_DELAY_STAGES
) (
    input wire core_clk_i,
    input wire reset_n_i,
    // fabric side
    input wire drive_data_i,
    input wire feed_through_i,
    input wire cell_clk_i,
    input wire capture_clock_enable_i,
    input wire capture_set_reset_i,
    input wire drive_clock_enable_i,
    input wire drive_set_reset_i,
    input wire drive_enable_request_i,
    input wire capture_enable_i,
    // pad buffer and global
    input wire pad_rx_i,
    input wire global_set_reset_i,
    // serial block side
    input wire serial_pass_i,
    input wire serial_mux_i,
    // configuration port
    input wire [`PIOC_ADDR_W-1:0] reg_addr_i,
    input wire [`PIOC_DATA_W-1:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    output reg [`PIOC_DATA_W-1:0] reg_rdata_o,
    // outputs
    output reg routing_result_a_o,
    output reg routing_result_b_o,
    output reg routed_drive_enable_o,
    output reg pad_tx_o,
    output reg pad_oe_o,
    output reg serial_pass_o,
    output reg serial_tx_o,
    output reg serial_oe_o
);

    reg [`PIOC_CFG_W-1:0] config_reg;
    reg pad_rx_meta;
    reg pad_rx_sync;
    reg cell_clk_prev;
    reg [CAP_DELAY_STAGES-1:0] cap_delay_line;
    wire cell_rise;
    wire cell_fall;
    wire active_edge;
    wire gate_level;
    wire capture_in;
    wire capture_d;
    wire cap_sr;
    wire drv_sr;
    wire [`PIOC_N_STOR-1:0] stor_latch;
    wire [`PIOC_N_STOR-1:0] stor_ce;
    wire [`PIOC_N_STOR-1:0] stor_sr;
    wire [`PIOC_N_STOR-1:0] stor_sr_val;
    wire [`PIOC_N_STOR-1:0] stor_d;
    wire [`PIOC_N_STOR-1:0] stor_q;
    wire [1:0] b_sel;
    reg next_result_b;
    wire next_result_a;
    wire next_pad_tx;
    wire next_pad_oe;
    wire [`PIOC_ST_W-1:0] status_word;

    // decode used by both the write and the read path
    function addr_hit;
        input [`PIOC_ADDR_W-1:0] addr;
        input [`PIOC_ADDR_W-1:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // configuration register
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_reg <= `PIOC_CFG_RESET;
        end else if (reg_write_i && addr_hit(reg_addr_i, `PIOC_OFS_CONFIG)) begin
            config_reg <= reg_wdata_i[`PIOC_CFG_W-1:0];
        end
    end

    // pad level comes from outside the core clock domain
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_rx_meta <= 1'b0;
            pad_rx_sync <= 1'b0;
        end else begin
            pad_rx_meta <= pad_rx_i; // RQ1
            pad_rx_sync <= pad_rx_meta;
        end
    end

    // cell clock is a fabric signal sampled by the core clock; its edges become enables
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cell_clk_prev <= 1'b0;
        end else begin
            cell_clk_prev <= cell_clk_i;
        end
    end

    assign cell_rise = cell_clk_i & ~cell_clk_prev;
    assign cell_fall = ~cell_clk_i & cell_clk_prev;
    assign active_edge = config_reg[`PIOC_CFG_CLK_FALL] ? cell_fall : cell_rise; // RQ10
    // latch is transparent during the active phase of the cell clock
    assign gate_level = config_reg[`PIOC_CFG_CLK_FALL] ? ~cell_clk_i : cell_clk_i; // RQ10

    // input gating before the capture path; disabled input reads as zero
    assign capture_in = capture_enable_i & pad_rx_sync;

    // optional delay line; costs a few cycles of latency but widens hold margin
    generate
        if (CAP_DELAY_STAGES == 1) begin : g_dly_one
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cap_delay_line <= {CAP_DELAY_STAGES{1'b0}};
                end else begin
                    cap_delay_line <= capture_in; // RQ7
                end
            end
        end else begin : g_dly_many
            always @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cap_delay_line <= {CAP_DELAY_STAGES{1'b0}};
                end else begin
                    cap_delay_line <= {cap_delay_line[CAP_DELAY_STAGES-2:0], capture_in}; // RQ7
                end
            end
        end
    endgenerate

    assign capture_d = config_reg[`PIOC_CFG_CAP_DELAY] ? cap_delay_line[CAP_DELAY_STAGES-1] : capture_in; // RQ7

    // set/reset terms, each merged with the global one
    assign cap_sr = global_set_reset_i | capture_set_reset_i; // RQ8
    assign drv_sr = global_set_reset_i | drive_set_reset_i; // RQ8

    // capture has its own pair, drive data and drive enable share the other
    assign stor_ce[`PIOC_IDX_CAP] = capture_clock_enable_i; // RQ9
    assign stor_ce[`PIOC_IDX_DRV] = drive_clock_enable_i; // RQ9
    assign stor_ce[`PIOC_IDX_OE] = drive_clock_enable_i; // RQ9
    assign stor_sr[`PIOC_IDX_CAP] = cap_sr; // RQ9
    assign stor_sr[`PIOC_IDX_DRV] = drv_sr; // RQ9
    assign stor_sr[`PIOC_IDX_OE] = drv_sr; // RQ9

    assign stor_latch[`PIOC_IDX_CAP] = config_reg[`PIOC_CFG_CAP_LATCH]; // RQ11
    assign stor_latch[`PIOC_IDX_DRV] = config_reg[`PIOC_CFG_DRV_LATCH]; // RQ11
    assign stor_latch[`PIOC_IDX_OE] = config_reg[`PIOC_CFG_OE_LATCH]; // RQ11

    assign stor_sr_val[`PIOC_IDX_CAP] = config_reg[`PIOC_CFG_CAP_SRVAL]; // RQ13
    assign stor_sr_val[`PIOC_IDX_DRV] = config_reg[`PIOC_CFG_DRV_SRVAL]; // RQ13
    assign stor_sr_val[`PIOC_IDX_OE] = config_reg[`PIOC_CFG_OE_SRVAL]; // RQ13

    assign stor_d[`PIOC_IDX_CAP] = capture_d;
    assign stor_d[`PIOC_IDX_DRV] = drive_data_i;
    assign stor_d[`PIOC_IDX_OE] = drive_enable_request_i;

    // three storage elements on one cell clock
    genvar gi;
    generate
        for (gi = 0; gi < `PIOC_N_STOR; gi = gi + 1) begin : g_stor
            pioc_stor u_stor ( // RQ6
                .core_clk_i(core_clk_i),
                .reset_n_i(reset_n_i),
                .edge_i(active_edge),
                .gate_i(gate_level),
                .latch_mode_i(stor_latch[gi]),
                .ce_i(stor_ce[gi]),
                .sr_i(stor_sr[gi]),
                .sr_val_i(stor_sr_val[gi]),
                .d_i(stor_d[gi]),
                .q_o(stor_q[gi])
            );
        end
    endgenerate

    // result a: registered capture or the bypassed pad level
    assign next_result_a = config_reg[`PIOC_CFG_A_REG] ? stor_q[`PIOC_IDX_CAP] : capture_in; // RQ2

    // result b selector
    assign b_sel = config_reg[`PIOC_CFG_B_SEL_HI:`PIOC_CFG_B_SEL_LO];

    always @* begin
        next_result_b = 1'b0;
        case (b_sel)
            `PIOC_BSEL_FEED: begin
                next_result_b = feed_through_i; // RQ4
            end
            `PIOC_BSEL_BYPASS: begin
                next_result_b = capture_in; // RQ4
            end
            `PIOC_BSEL_Q: begin
                next_result_b = stor_q[`PIOC_IDX_CAP]; // RQ4
            end
            `PIOC_BSEL_SERIAL: begin
                next_result_b = serial_mux_i; // RQ4
            end
            default: begin
                next_result_b = 1'b0;
            end
        endcase
    end

    // drive path: register or bypass
    assign next_pad_tx = config_reg[`PIOC_CFG_DRV_BYP] ? drive_data_i : stor_q[`PIOC_IDX_DRV];
    assign next_pad_oe = config_reg[`PIOC_CFG_OE_BYP] ? drive_enable_request_i : stor_q[`PIOC_IDX_OE]; // RQ12

    // output stage: every result leaves a flip-flop, one cycle after its source
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            routing_result_a_o <= 1'b0;
            routing_result_b_o <= 1'b0;
            routed_drive_enable_o <= 1'b0;
            pad_tx_o <= 1'b0;
            pad_oe_o <= 1'b0;
            serial_pass_o <= 1'b0;
            serial_tx_o <= 1'b0;
            serial_oe_o <= 1'b0;
        end else begin
            routing_result_a_o <= next_result_a; // RQ2
            routing_result_b_o <= next_result_b; // RQ2
            routed_drive_enable_o <= next_pad_oe; // RQ12
            pad_tx_o <= next_pad_tx; // RQ2
            pad_oe_o <= next_pad_oe; // RQ2
            serial_pass_o <= serial_pass_i; // RQ4
            // same sources and same stage as the pad pair, so the copies never skew
            serial_tx_o <= next_pad_tx; // RQ5
            serial_oe_o <= next_pad_oe; // RQ5
        end
    end

    // status view of the three storage elements, the synchronized pad level and serial_mux_i
    assign status_word[`PIOC_ST_CAP_Q] = stor_q[`PIOC_IDX_CAP];
    assign status_word[`PIOC_ST_DRV_Q] = stor_q[`PIOC_IDX_DRV];
    assign status_word[`PIOC_ST_OE_Q] = stor_q[`PIOC_IDX_OE];
    assign status_word[`PIOC_ST_PAD_RX] = pad_rx_sync;
    assign status_word[`PIOC_ST_SER_B] = serial_mux_i; // RQ3

    // read data one cycle after the strobe; unmapped or idle reads give zero
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= {`PIOC_DATA_W{1'b0}};
        end else if (reg_read_i && addr_hit(reg_addr_i, `PIOC_OFS_CONFIG)) begin
            reg_rdata_o <= {{(`PIOC_DATA_W-`PIOC_CFG_W){1'b0}}, config_reg};
        end else if (reg_read_i && addr_hit(reg_addr_i, `PIOC_OFS_STATUS)) begin
            reg_rdata_o <= {{(`PIOC_DATA_W-`PIOC_ST_W){1'b0}}, status_word};
        end else begin
            reg_rdata_o <= {`PIOC_DATA_W{1'b0}};
        end
    end

endmodule // pioc_cell

/* File: tb/pioc_pad_model.sv */
// pad buffer model: the pad line seen by the cell's receive input
// assumes the bench may drive the pad from outside while the cell is not driving
module pioc_pad_model (
    input wire pad_tx_i,
    input wire pad_oe_i,
    input wire ext_level_i,
    input wire ext_drive_i,
    output wire pad_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // weak pull-up, so an undriven pad reads as one whatever was last driven
    assign pad_level_o = pad_oe_i ? pad_tx_i : (ext_drive_i ? ext_level_i : 1'b1);
endmodule // pioc_pad_model

/* File: tb/pioc_cell_asserts.sv */
// port checker for the pad cell
// assumes config at offset 0x0 and a bind onto every pioc_cell
module pioc_cell_chk (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire drive_data_i,
    input wire cell_clk_i,
    input wire drive_clock_enable_i,
    input wire drive_set_reset_i,
    input wire global_set_reset_i,
    input wire serial_pass_i,
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    input wire [31:0] reg_rdata_o,
    input wire routed_drive_enable_o,
    input wire pad_tx_o,
    input wire pad_oe_o,
    input wire serial_pass_o,
    input wire serial_tx_o,
    input wire serial_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [12:0] cfg;
    wire sr_d = drive_set_reset_i || global_set_reset_i;
    // shadow of the config word, kept here so checks follow mode changes
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) cfg <= 13'h0000;
        else if (reg_write_i && reg_addr_i == 4'h0) cfg <= reg_wdata_i[12:0];
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    serial_copy_a: assert property (serial_tx_o == pad_tx_o && serial_oe_o == pad_oe_o)
        else $error("serial copies differ from pad outputs");
    cluster_oe_a: assert property (routed_drive_enable_o == pad_oe_o)
        else $error("routed enable differs from pad enable");
    serial_pass_a: assert property ($past(reset_n_i) |-> serial_pass_o == $past(serial_pass_i))
        else $error("serial pass-through wrong");
    cfg_read_a: assert property (reg_read_i && reg_addr_i == 4'h0 |=> reg_rdata_o == {19'h0, cfg})
        else $error("config readback wrong");
    drive_sr_a: assert property (sr_d [*2] ##0 !cfg[11] |=> pad_tx_o == $past(cfg[5], 2))
        else $error("drive data not forced by set/reset");
    oe_sr_a: assert property (sr_d [*2] ##0 !cfg[12] |=> pad_oe_o == $past(cfg[6], 2))
        else $error("drive enable not forced by set/reset");
    drive_hold_a: assert property ((!drive_clock_enable_i && !sr_d && !cfg[11]) [*2] |=> $stable(pad_tx_o))
        else $error("drive data moved with clock enable low");
    edge_load_a: assert property ($past(reset_n_i) && (cfg[0] ? $fell(cell_clk_i) : $rose(cell_clk_i))
        && drive_clock_enable_i && !sr_d && !reg_write_i && !cfg[2] && !cfg[11] ##1 !sr_d && !reg_write_i
        |=> pad_tx_o == $past(drive_data_i, 2)) else $error("drive data not loaded on active edge");
endmodule // pioc_cell_chk
bind pioc_cell pioc_cell_chk chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .drive_data_i(drive_data_i),
    .cell_clk_i(cell_clk_i), .drive_clock_enable_i(drive_clock_enable_i), .drive_set_reset_i(drive_set_reset_i),
    .global_set_reset_i(global_set_reset_i), .serial_pass_i(serial_pass_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .routed_drive_enable_o(routed_drive_enable_o), .pad_tx_o(pad_tx_o), .pad_oe_o(pad_oe_o),
    .serial_pass_o(serial_pass_o), .serial_tx_o(serial_tx_o), .serial_oe_o(serial_oe_o));

/* File: tb/testbench.sv */
// self-checking bench for the pad cell with a pad buffer model
// assumes config at 0x0, status at 0x4, one-cycle output pipeline
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, dd = 0, ft = 0, cclk = 0, cce = 0, csr = 0, dce = 0, dsr = 0, oreq = 0, cen = 0;
    logic global_set_reset = 0, spass = 0, smux = 0, we = 0, re = 0, ext_lvl = 0, ext_drv = 0, pad;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    wire [31:0] rdata;
    wire ra, rb, rde, ptx, poe, spo, stx, soe;
    int miscompares = 0, num_checks = 0, cycles = 0, n0, n1;
    pioc_cell #(.CAP_DELAY_STAGES(2)) uut (.core_clk_i(clk), .reset_n_i(rst_n), .drive_data_i(dd),
        .feed_through_i(ft), .cell_clk_i(cclk), .capture_clock_enable_i(cce), .capture_set_reset_i(csr),
        .drive_clock_enable_i(dce), .drive_set_reset_i(dsr), .drive_enable_request_i(oreq),
        .capture_enable_i(cen), .pad_rx_i(pad), .global_set_reset_i(global_set_reset), .serial_pass_i(spass),
        .serial_mux_i(smux), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_write_i(we), .reg_read_i(re),
        .reg_rdata_o(rdata), .routing_result_a_o(ra), .routing_result_b_o(rb), .routed_drive_enable_o(rde),
        .pad_tx_o(ptx), .pad_oe_o(poe), .serial_pass_o(spo), .serial_tx_o(stx), .serial_oe_o(soe));
    pioc_pad_model pad_buf (.pad_tx_i(ptx), .pad_oe_i(poe), .ext_level_i(ext_lvl), .ext_drive_i(ext_drv),
        .pad_level_o(pad));
    initial begin
        forever #10 clk = ~clk;
    end
    task cyc(input int n); repeat (n) @(posedge clk); endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk); we <= 1; addr <= a; wd <= d;
        @(posedge clk); we <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk); re <= 1; addr <= a;
        @(posedge clk); re <= 0;
        @(negedge clk); rdat = rdata;
    endtask
    task settle(input int n); cyc(n); @(negedge clk); endtask
    task t_regs;
        rd(4'h0); chk("cfg reset", rdat, 32'h0);
        wr(4'h0, 32'hffffffff); rd(4'h0); chk("cfg mask", rdat, 32'h1fff);
        rd(4'h8); chk("unmapped", rdat, 32'h0);
        wr(4'h0, 32'h0); $display("regs done");
    endtask
    task t_edge;
        dd <= 1; dce <= 1; @(posedge clk) cclk <= 1; settle(2);
        chk("tx rise", ptx, 1); chk("ser tx", stx, 1);
        wr(4'h0, 32'h1); dd <= 0; @(posedge clk) cclk <= 0; settle(2); chk("tx fall", ptx, 0);
        @(posedge clk) dd <= 1;
        @(posedge clk) cclk <= 1;
        settle(3); chk("rise ignored", ptx, 0);
        wr(4'h0, 32'h4); dd <= 1; settle(3); chk("latch open", ptx, 1);
        @(posedge clk) cclk <= 0;
        @(posedge clk) dd <= 0;
        settle(3); chk("latch shut", ptx, 1);
        $display("edge done");
    endtask
    task t_sr;
        wr(4'h0, 32'h60); dce <= 0; dsr <= 1; cyc(2); dsr <= 0; settle(2);
        chk("sr tx", ptx, 1); chk("sr oe", poe, 1); chk("sr rde", rde, 1);
        wr(4'h0, 32'h0); global_set_reset <= 1; cyc(2); global_set_reset <= 0; settle(2); chk("gsr tx", ptx, 0);
        wr(4'h0, 32'h10); csr <= 1; cyc(2); csr <= 0; rd(4'h4); chk("cap sr only", rdat[2:0], 3'h1);
        $display("sr done");
    endtask
    task measure(input logic [31:0] c, output int n);
        wr(4'h0, c); ext_lvl <= 0; cyc(10); n = 0;
        @(posedge clk) ext_lvl <= 1;
        // look between edges so the result is settled
        @(negedge clk);
        while (rb !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    endtask
    task t_capture;
        @(posedge clk) ext_drv <= 1;
        cen <= 1; cce <= 1; cclk <= 1;
        measure(32'h202, n0); measure(32'h282, n1); chk("sync depth", n0, 4);
        chk("delay adds", n1, n0 + 2);
        chk("a bypass", ra, 1);
        wr(4'h0, 32'h300); ext_lvl <= 0; smux <= 1; spass <= 1; settle(6);
        chk("b serial", rb, 1); chk("pass", spo, 1); chk("a low", ra, 0);
        wr(4'h0, 32'h0); ft <= 1; smux <= 0; settle(3); chk("b feed", rb, 1);
        $display("capture done");
    endtask
    task t_reset;
        @(posedge clk) rst_n <= 0; settle(1); chk("rst oe", poe, 0); chk("rst pass", spo, 0);
        @(posedge clk) rst_n <= 1; rd(4'h0); chk("rst cfg", rdat, 32'h0);
        $display("reset done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin miscompares++; tally_and_finish; end
    end
    initial begin
        cyc(5); rst_n <= 1;
        t_regs; t_edge; t_sr; t_capture; t_reset;
        tally_and_finish;
    end
endmodule // testbench
